// ### rtl/srp_pkg.sv
package srp_pkg;

  // ==========================================================
  // Frame layout
  localparam int SRP_HDR_BITS = 16;
  localparam int SRP_ADDR_W = 15;
  localparam int SRP_DATA_W = 8;
  localparam logic [3:0] SRP_HDR_LAST = 4'hF;
  localparam logic [2:0] SRP_BYTE_LAST = 3'h7;

  // ==========================================================
  // Register storage
  localparam int SRP_MEM_AW = 6;
  localparam int SRP_MEM_DEPTH = 64;
  localparam logic [14:0] SRP_CFG_A_ADDR = 15'h0000;
  localparam logic [14:0] SRP_USR_CFG_ADDR = 15'h0010;
  localparam int SRP_ASC_BIT_HI = 5;
  localparam int SRP_ASC_BIT_LO = 2;
  localparam int SRP_HOLD_BIT = 0;
  localparam logic [7:0] SRP_CFG_A_RST = 8'h30;
  localparam logic [7:0] SRP_USR_CFG_RST = 8'h00;
  localparam logic [7:0] SRP_MEM_RST = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic rd;
    logic [SRP_ADDR_W-1:0] addr;
  } srp_hdr_type;

  typedef enum {
    SRP_HEADER,
    SRP_DATA
  } srp_phase_type;

endpackage : srp_pkg

// ### rtl/srp_regmem.sv
`timescale 1ns/1ps
module srp_regmem (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic we_in,
  input wire logic [srp_pkg::SRP_MEM_AW-1:0] waddr_in,
  input wire logic [srp_pkg::SRP_DATA_W-1:0] wdata_in,
  input wire logic [srp_pkg::SRP_MEM_AW-1:0] raddr_in,
  output logic [srp_pkg::SRP_DATA_W-1:0] rdata_out
);
  import srp_pkg::*;

  logic [SRP_DATA_W-1:0] mem_reg [SRP_MEM_DEPTH];

  // ==========================================================
  // Storage, reset so reads are defined from the start
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < SRP_MEM_DEPTH; i++) begin
        mem_reg[i] <= (i == 0) ? SRP_CFG_A_RST : SRP_MEM_RST;
      end
    end else if (we_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= SRP_MEM_RST;
    end else begin
      rdata_out <= mem_reg[raddr_in];
    end
  end

endmodule : srp_regmem

// ### rtl/srp_port.sv
`timescale 1ns/1ps
module srp_port (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_clock_in,
  input wire logic serial_select_n_in,
  input wire logic serial_data_input_in,
  output logic serial_data_output_out,
  output logic serial_data_output_oe_out
);
  import srp_pkg::*;

  logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
  logic sel_n_meta_reg, sel_n_sync_reg;
  logic sdi_meta_reg, sdi_sync_reg;
  logic active, sclk_rise, sclk_fall;
  srp_phase_type phase_reg;
  srp_hdr_type hdr_reg;
  logic [3:0] hdr_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [SRP_DATA_W-1:0] shift_in_reg, shift_out_reg;
  logic [SRP_ADDR_W-1:0] cur_addr_reg, addr_next;
  logic [SRP_ADDR_W-1:0] hdr_addr_next;
  logic mem_we_reg;
  logic [SRP_MEM_AW-1:0] mem_waddr_reg;
  logic [SRP_DATA_W-1:0] mem_wdata_reg, mem_rdata, rd_byte;
  logic [SRP_ADDR_W-1:0] wr_addr_full_reg;
  logic rd_range_reg, cur_in_range, byte_done;
  logic asc_hi_reg, asc_lo_reg, hold_reg;

  // ==========================================================
  // Pin synchronisers; serial clock is sampled, not used as a clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      sel_n_meta_reg <= 1'b1;
      sel_n_sync_reg <= 1'b1;
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= serial_clock_in;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      sel_n_meta_reg <= serial_select_n_in;
      sel_n_sync_reg <= sel_n_meta_reg;
      sdi_meta_reg <= serial_data_input_in;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  assign active = ~sel_n_sync_reg;
  assign sclk_rise = active & sclk_sync_reg & ~sclk_prev_reg;
  assign sclk_fall = active & ~sclk_sync_reg & sclk_prev_reg;
  assign cur_in_range = (cur_addr_reg >> SRP_MEM_AW) == '0;
  assign byte_done = sclk_rise && phase_reg == SRP_DATA && bit_cnt_reg == SRP_BYTE_LAST;
  assign hdr_addr_next = {hdr_reg.addr[SRP_ADDR_W-2:0], sdi_sync_reg};

  // Ascending by default keeps multi-byte registers little endian
  always_comb begin
    if (hold_reg) begin
      addr_next = cur_addr_reg;
    end else if (asc_hi_reg | asc_lo_reg) begin
      addr_next = cur_addr_reg + 15'h0001;
    end else begin
      addr_next = cur_addr_reg - 15'h0001;
    end
  end

  // ==========================================================
  // Frame tracking; only edges advance it, so no timeout exists
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= SRP_HEADER;
      hdr_reg <= '0;
      hdr_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      shift_in_reg <= '0;
      cur_addr_reg <= '0;
    end else if (!active) begin
      phase_reg <= SRP_HEADER;
      hdr_cnt_reg <= '0;
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      case (phase_reg)
        SRP_HEADER: begin
          hdr_reg <= {hdr_reg[SRP_HDR_BITS-2:0], sdi_sync_reg};
          hdr_cnt_reg <= hdr_cnt_reg + 4'h1;
          if (hdr_cnt_reg == SRP_HDR_LAST) begin
            phase_reg <= SRP_DATA;
            cur_addr_reg <= hdr_addr_next;
          end
        end
        SRP_DATA: begin
          shift_in_reg <= {shift_in_reg[SRP_DATA_W-2:0], sdi_sync_reg};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == SRP_BYTE_LAST) begin
            cur_addr_reg <= addr_next;
          end
        end
        default: begin
          phase_reg <= SRP_HEADER;
        end
      endcase
    end
  end

  // ==========================================================
  // Write strobe, one clock after the last data bit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_we_reg <= 1'b0;
      mem_waddr_reg <= '0;
      mem_wdata_reg <= '0;
      wr_addr_full_reg <= '0;
    end else begin
      mem_we_reg <= byte_done && !hdr_reg.rd && cur_in_range;
      mem_waddr_reg <= cur_addr_reg[SRP_MEM_AW-1:0];
      mem_wdata_reg <= {shift_in_reg[SRP_DATA_W-2:0], sdi_sync_reg};
      wr_addr_full_reg <= cur_addr_reg;
    end
  end

  // Shadow copies of the steering bits, kept in step with storage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      asc_hi_reg <= SRP_CFG_A_RST[SRP_ASC_BIT_HI];
      asc_lo_reg <= SRP_CFG_A_RST[SRP_ASC_BIT_LO];
      hold_reg <= SRP_USR_CFG_RST[SRP_HOLD_BIT];
    end else if (mem_we_reg) begin
      if (wr_addr_full_reg == SRP_CFG_A_ADDR) begin
        asc_hi_reg <= mem_wdata_reg[SRP_ASC_BIT_HI];
        asc_lo_reg <= mem_wdata_reg[SRP_ASC_BIT_LO];
      end
      if (wr_addr_full_reg == SRP_USR_CFG_ADDR) begin
        hold_reg <= mem_wdata_reg[SRP_HOLD_BIT];
      end
    end
  end

  srp_regmem u_mem (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .we_in(mem_we_reg),
    .waddr_in(mem_waddr_reg),
    .wdata_in(mem_wdata_reg),
    .raddr_in(cur_addr_reg[SRP_MEM_AW-1:0]),
    .rdata_out(mem_rdata)
  );

  // ==========================================================
  // Read path; unmapped addresses read as zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_range_reg <= 1'b0;
    end else begin
      rd_range_reg <= cur_in_range;
    end
  end

  assign rd_byte = rd_range_reg ? mem_rdata : '0;

  // Output only moves on falling edges, giving the host half a period
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_data_output_out <= 1'b0;
      serial_data_output_oe_out <= 1'b0;
      shift_out_reg <= '0;
    end else if (!active) begin
      serial_data_output_oe_out <= 1'b0;
    end else if (sclk_fall && phase_reg == SRP_DATA && hdr_reg.rd) begin
      serial_data_output_oe_out <= 1'b1;
      if (bit_cnt_reg == 3'h0) begin
        serial_data_output_out <= rd_byte[SRP_DATA_W-1];
        shift_out_reg <= {rd_byte[SRP_DATA_W-2:0], 1'b0};
      end else begin
        serial_data_output_out <= shift_out_reg[SRP_DATA_W-1];
        shift_out_reg <= {shift_out_reg[SRP_DATA_W-2:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Checks
  a_release_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    !active |=> !serial_data_output_oe_out)
    else $error("output driven while deselected");

  a_release_header: assert property (@(posedge clk_in) disable iff (rst_in)
    (phase_reg == SRP_HEADER) |-> !serial_data_output_oe_out)
    else $error("output driven during header");

  a_release_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (phase_reg == SRP_DATA && !hdr_reg.rd) |-> !serial_data_output_oe_out)
    else $error("output driven during write");

  a_write_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    mem_we_reg |-> $past(byte_done) && !hdr_reg.rd)
    else $error("write strobe without finished write byte");

  a_header_end: assert property (@(posedge clk_in) disable iff (rst_in)
    (sclk_rise && phase_reg == SRP_HEADER && hdr_cnt_reg == SRP_HDR_LAST)
      |=> phase_reg == SRP_DATA && cur_addr_reg == hdr_reg.addr)
    else $error("header not closed after sixteen bits");

  a_dir_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (sclk_rise && phase_reg == SRP_HEADER && hdr_cnt_reg == 4'h0)
      |=> hdr_reg[0] == $past(sdi_sync_reg))
    else $error("direction bit not captured");

  a_addr_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (byte_done && !hold_reg && asc_hi_reg) |=> cur_addr_reg == $past(cur_addr_reg) + 15'h0001)
    else $error("address did not ascend");

  a_addr_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (byte_done && hold_reg) |=> $stable(cur_addr_reg))
    else $error("address moved while held");

  a_out_on_fall: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(serial_data_output_out) |-> $past(sclk_fall))
    else $error("output changed off a falling edge");

  a_pause_safe: assert property (@(posedge clk_in) disable iff (rst_in)
    (active && !sclk_rise && phase_reg == SRP_DATA) |=> phase_reg == SRP_DATA)
    else $error("frame dropped while clock paused");

  c_write_byte: cover property (@(posedge clk_in) disable iff (rst_in) mem_we_reg);
  c_read_drive: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(serial_data_output_oe_out));
  c_stream: cover property (@(posedge clk_in) disable iff (rst_in)
    byte_done ##[1:200] byte_done);
  c_abort: cover property (@(posedge clk_in) disable iff (rst_in)
    phase_reg == SRP_DATA && bit_cnt_reg != 3'h0 ##1 !active);

endmodule : srp_port

// ### test/srp_host_model.sv
`timescale 1ns/1ps
module srp_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic oe_in
);
  // Half period of the link clock; a large value mimics a paused host
  int half = 40;
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // ==========================================================
  // One framed transfer, nbits clocks, data right aligned in wd
  task automatic xfer(input logic [15:0] hdr, input int nbits, input logic [63:0] wd,
                      output logic [63:0] rd, output logic oe_bad);
    logic [79:0] sh;
    sh = {hdr, 64'(wd << (80 - nbits))};
    rd = '0;
    oe_bad = 1'b0;
    // Pins move on clock edges by non-blocking update, so no race with sampling
    @(posedge clk_in);
    sel_n_out <= 1'b0; // Clock idle low when select falls
    for (int i = 0; i < nbits; i++) begin
      sdi_out <= sh[79 - i]; // Direction, address, data, MSB first
      #(half);
      sclk_out <= 1'b1;
      #(half);
      // Sample late in high phase: bit is held until after the falling edge
      rd = {rd[62:0], sdo_in};
      if ((i < 16 || !hdr[15]) && oe_in === 1'b1) begin
        oe_bad = 1'b1;
      end
      sclk_out <= 1'b0;
    end
    #(half);
    sel_n_out <= 1'b1; // Whole access inside one select low
    sdi_out <= ~sdi_out; // Released line shows no stale bit
    #(half);
  endtask : xfer
endmodule : srp_host_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import srp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk, sel_n, serial_data_input, serial_data_output, oe, oe_bad;
  wire sdo_line = oe ? serial_data_output : 1'bz;
  int fail_count = 0;
  int check_count = 0;
  logic [63:0] rv;
  srp_port srp_port_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .serial_clock_in(sclk),
    .serial_select_n_in(sel_n),
    .serial_data_input_in(serial_data_input),
    .serial_data_output_out(serial_data_output),
    .serial_data_output_oe_out(oe)
  );
  srp_host_model srp_host_model_inst (
    .clk_in(clk_in),
    .sclk_out(sclk),
    .sel_n_out(sel_n),
    .sdi_out(serial_data_input),
    .sdo_in(sdo_line),
    .oe_in(oe)
  );
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic rd, input logic [14:0] a, input int nbits, input logic [63:0] wd);
    srp_hdr_type h;
    h.rd = rd;
    h.addr = a;
    srp_host_model_inst.xfer(h, nbits, wd, rv, oe_bad);
    chk({63'h0, oe_bad}, 64'h0);
    chk({63'h0, oe}, 64'h0);
  endtask : acc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    acc(1'b1, 15'h0000, 24, 64'h0);
    chk(rv[7:0], 8'h30);
    acc(1'b1, 15'h0010, 24, 64'h0);
    chk(rv[7:0], 8'h00);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_single;
    for (int k = 0; k < 2; k++) begin
      srp_host_model_inst.half = (k == 0) ? 40 : 400;
      acc(1'b0, 15'h0012, 24, 64'hA5 ^ k);
      acc(1'b1, 15'h0012, 24, 64'h5A);
      chk(rv[7:0], 8'hA5 ^ k);
      acc(1'b1, 15'h0012, 24, 64'h0);
      chk(rv[7:0], 8'hA5 ^ k);
    end
    srp_host_model_inst.half = 40;
    acc(1'b0, 15'h7FFF, 24, 64'hEE);
    acc(1'b1, 15'h7FFF, 24, 64'h0);
    chk(rv[7:0], 8'h00);
    $display("test single access done");
  endtask : t_single
  task automatic t_stream;
    acc(1'b0, 15'h0020, 40, 64'h11_2233);
    acc(1'b1, 15'h0020, 48, 64'h0);
    chk(rv[31:0], 32'h1122_3300);
    acc(1'b0, 15'h0000, 24, 64'h0);
    acc(1'b0, 15'h0030, 32, 64'h4455);
    acc(1'b0, 15'h0000, 24, 64'h30);
    acc(1'b1, 15'h002F, 32, 64'h0);
    chk(rv[15:0], 16'h5544);
    $display("test streaming done");
  endtask : t_stream
  task automatic t_hold;
    acc(1'b0, 15'h0010, 24, 64'h01);
    acc(1'b0, 15'h0028, 32, 64'h6677);
    acc(1'b1, 15'h0028, 32, 64'h0);
    chk(rv[15:0], 16'h7777);
    acc(1'b0, 15'h0010, 24, 64'h00);
    acc(1'b1, 15'h0029, 24, 64'h0);
    chk(rv[7:0], 8'h00);
    $display("test address hold done");
  endtask : t_hold
  task automatic t_abort;
    acc(1'b0, 15'h0031, 20, 64'hF);
    acc(1'b0, 15'h0032, 30, 64'h3F_FF);
    acc(1'b1, 15'h0031, 32, 64'h0);
    // First byte out is 0x031 (never stored), then 0x032
    chk(rv[15:0], 16'h00FF);
    $display("test aborted frame done");
  endtask : t_abort
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk({63'h0, oe}, 64'h0);
    t_reset();
    t_single();
    t_stream();
    t_hold();
    t_abort();
    tally_and_finish();
  end
  initial begin
    // About eleven thousand cycles expected; margin of four times
    #500us;
    fail_count++;
    tally_and_finish();
  end
endmodule : testbench
